//--- bench/remote_lane.sv
/*
  Far-end lane model: sends PRBS words to the checker, with an optional
  flipped last bit. Assumes one clock shared with the block, W of 20.
*/
`timescale 1ns/1ns
`include "lane_test_consts.svh"

module remote_lane (
  // Clock
  input  wire logic        clk,
  // Mode and error injection
  input  wire logic [2:0]  sel,
  input  wire logic        flip,
  // Line word, bit 0 first
  output logic      [19:0] word = 20'h0
);
  logic [30:0] state_q = 31'h7FFFFFFF;
  logic [2:0]  sel_q   = 3'h0;
  logic [50:0] nxt;

  // One word of a Fibonacci shift register; d replaces feedback if use_d
  function automatic logic [50:0] step(input logic [30:0] s, input logic [2:0] m,
                                       input logic [19:0] d, input logic use_d);
    logic [19:0] w;
    logic        fb;
    int          ta;
    int          tb;
    ta = m == 3'h1 ? `TAP7_A : m == 3'h2 ? `TAP15_A : m == 3'h3 ? `TAP23_A : `TAP31_A;
    tb = m == 3'h1 ? `TAP7_B : m == 3'h2 ? `TAP15_B : m == 3'h3 ? `TAP23_B : `TAP31_B;
    for (int i = 0; i < 20; i++)
    begin
      fb   = s[ta] ^ s[tb];
      w[i] = fb;
      s    = {s[29:0], use_d ? d[i] : fb};
    end
    return {s, w};
  endfunction : step

  always_comb nxt = step(state_q, sel, 20'h0, 1'b0);

  // Reseed on a mode change; outside PRBS modes the line alternates between two words
  always @(posedge clk)
  begin
    sel_q <= sel;
    if (sel != sel_q)
    begin
      state_q <= 31'h7FFFFFFF;
      word    <= ~word;
    end
    else if (sel != 3'h0 && sel <= 3'h4)
    begin
      state_q <= nxt[50:20];
      word    <= nxt[19:0] ^ {flip, 19'h0};
    end
    else
      word <= ~word ^ 20'h12345;
  end
endmodule : remote_lane

//--- bench/tb_lane_prbs_pattern_test.sv
/*
  Self-checking bench for the lane test block, W of 20. Assumes the
  remote_lane model feeds the receive side; inputs change at negedge.
*/
`timescale 1ns/1ns

module tb_lane_prbs_pattern_test;
  logic        clk, rstn, nlock, force_e, clr, flip, err, locked;
  logic [2:0]  tsel, rsel, psel;
  logic [19:0] tdi, tdo, rdi, a, p;
  logic [15:0] cnt;
  logic [7:0]  dm;
  logic [50:0] r;
  logic [30:0] h;
  int          fails, comparisons, n;
  localparam logic [39:0] CP = 40'hAAA835557C;

  lane_prbs_pattern_test uut (.clk(clk), .rstn(rstn), .clk_not_locked(nlock), .tx_sel(tsel),
    .tx_force_err(force_e), .tx_data_in(tdi), .tx_data_out(tdo), .rx_sel(rsel),
    .rx_data_in(rdi), .rx_cnt_clr(clr), .rx_err(err), .rx_err_cnt(cnt), .locked(locked),
    .dmon_out(dm));
  remote_lane peer (.clk(clk), .sel(psel), .flip(flip), .word(rdi));

  // Compare and count
  task chk(input string nm, input logic [39:0] seen, input logic [39:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      fails++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task results;
    if (fails == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : results

  task tick(input int k);
    repeat (k) @(negedge clk);
  endtask : tick

  // Clock, 20 ns period; the lock synchroniser inside the block runs on it too
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Watchdog, far beyond the few hundred cycles needed
  initial
  begin
    #200000;
    fails++;
    results();
  end

  initial
  begin
    {rstn, force_e, clr, flip, nlock} = 5'h0;
    {tsel, rsel, psel, tdi} = 29'h0;
    void'($urandom(32'h0154));
    tick(2);
    rstn = 1'b1;
    chk("rst_tx", tdo, 20'h0);
    chk("rst_cnt", cnt, 16'h0);
    tick(3);
    chk("locked", locked, 1'b1);
    // Pass-through, force ignored
    repeat (20)
    begin
      tdi     = 20'($urandom);
      force_e = 1'($urandom);
      tick(1);
      chk("tx_pass", tdo, tdi);
    end
    force_e = 1'b0;
    tsel = 3'h6;
    tick(3);
    chk("sq2", tdo, 20'hAAAAA);
    tsel = 3'h7;
    tick(3);
    chk("sqw", tdo, 20'h003FF);
    tsel = 3'h5;
    tick(3);
    a = tdo;
    tick(1);
    chk("compl", {a, tdo} == CP || {tdo, a} == CP, 1'b1);
    // Generator: each word follows from the previous 31 bits
    for (int k = 1; k <= 4; k++)
    begin
      tsel = 3'(k);
      tick(3);
      r = peer.step(31'h0, tsel, tdo, 1'b1);
      tick(1);
      r = peer.step(r[50:20], tsel, tdo, 1'b1);
      h = r[50:20];
      for (int j = 0; j < 7; j++)
      begin
        force_e = j == 6;
        tick(1);
        r = peer.step(h, tsel, 20'h0, 1'b0);
        p = r[19:0];
        r = peer.step(h, tsel, tdo, 1'b1);
        h = r[50:20];
        chk("tx_prbs", tdo ^ p, {19'h0, force_e});
      end
      force_e = 1'b0;
    end
    // Checker: quiet after change, burst on one bad bit, clear
    for (int k = 1; k <= 4; k++)
    begin
      rsel = 3'(k);
      psel = 3'(k);
      tick(8);
      chk("rx_quiet", {err, cnt}, 17'h0);
      flip = 1'b1;
      tick(1);
      flip = 1'b0;
      n = 0;
      repeat (12)
      begin
        tick(1);
        n += err;
      end
      chk("burst", n > 1, 1'b1);
      chk("cnt", cnt, 16'(n));
      chk("err_drop", err, 1'b0);
      chk("dmon", dm, 8'(n));
      clr = 1'b1;
      tick(1);
      clr = 1'b0;
      chk("clr", cnt, 16'h0);
    end
    // Checking off, line full of errors
    rsel = 3'h0;
    tick(2);
    repeat (20)
    begin
      flip = 1'($urandom);
      tick(1);
      chk("off", {err, cnt}, 17'h0);
    end
    tsel  = 3'h6;
    nlock = 1'b1;
    tick(4);
    chk("unlock", {locked, tdo}, 21'h0);
    results();
  end
endmodule : tb_lane_prbs_pattern_test

//--- hw/lane_prbs_pattern_test.sv
/*
  Per-lane test pattern generator and pattern checker on the parallel
  user clock. Assumes rx data and all controls are on clk; only the
  clock-not-locked level comes from outside and is synchronised here.
*/
`timescale 1ns/1ns
`include "lane_test_consts.svh"

module lane_prbs_pattern_test
  import lane_test_pkg::*;
#(
  parameter int W      = 20,
  parameter int CNT_W  = 16,
  parameter int DMON_W = 8
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rstn,
  // Clock lock from the clock module, asynchronous
  input  wire logic              clk_not_locked,
  // Transmit side
  input  wire logic [2:0]        tx_sel,
  input  wire logic              tx_force_err,
  input  wire logic [W-1:0]      tx_data_in,
  output logic      [W-1:0]      tx_data_out,
  // Receive side
  input  wire logic [2:0]        rx_sel,
  input  wire logic [W-1:0]      rx_data_in,
  input  wire logic              rx_cnt_clr,
  output logic                   rx_err,
  output logic      [CNT_W-1:0]  rx_err_cnt,
  // Status
  output logic                   locked,
  output logic      [DMON_W-1:0] dmon_out
);

  // Lock synchroniser; first stage feeds only the second
  logic lk_meta_q;
  logic lk_sync_q;
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      lk_meta_q <= 1'b1;
      lk_sync_q <= 1'b1;
    end
    else
    begin
      lk_meta_q <= clk_not_locked;
      lk_sync_q <= lk_meta_q;
    end
  end
  assign locked = !lk_sync_q;

  // Transmit state
  pat_e         pat;
  logic [30:0]  gen_q, gen_d, gen_nxt;
  logic [W-1:0] gen_bits, compl_w, sq2_w, sqw_w;
  logic [W-1:0] txo_d;
  logic         ph_q, ph_d;
  logic [2:0]   txs_q;

  prbs_step #(.W(W)) u_gen (
    .state_i   (gen_q),
    .sel_i     (tx_sel),
    .use_ref_i (1'b0),
    .ref_i     ('0),
    .bits_o    (gen_bits),
    .state_o   (gen_nxt)
  );

  // Select decode
  always_comb
  begin
    case (tx_sel)
      `SEL_OFF:    pat = PAT_OFF;
      `SEL_COMPL:  pat = PAT_COMPL;
      `SEL_SQ2:    pat = PAT_SQ2;
      `SEL_SQW:    pat = PAT_SQW;
      default:     pat = PAT_PRBS;
    endcase
  end

  // Compliance word as a vector, so each bit is picked, not truncated
  localparam logic [39:0] COMPL_P = `COMPL_PAT;

  // Fixed patterns; compliance only exists at 20 and 40 bit widths
  // Other widths send zeros rather than a cut pattern
  always_comb
  begin
    int idx;
    idx     = 0;
    compl_w = '0;
    for (int i = 0; i < W; i++)
    begin
      sq2_w[i] = 1'(i % 2);
      sqw_w[i] = (i < W / 2);
      if (W == `COMPL_HALF || W == `COMPL_FULL)
      begin
        idx = (W == `COMPL_HALF && ph_q) ? i + `COMPL_HALF : i;
        compl_w[i] = COMPL_P[idx];
      end
    end
  end

  // Next transmit word and generator state
  always_comb
  begin
    gen_d = gen_q;
    ph_d  = ph_q;
    txo_d = tx_data_in;
    if (!locked)
    begin
      // Held quiet until the clock is stable
      gen_d = `PRBS_SEED;
      ph_d  = 1'b0;
      txo_d = '0;
    end
    else if (tx_sel != txs_q)
    begin
      // Restart so compliance always opens with its low half
      gen_d = `PRBS_SEED;
      ph_d  = 1'b0;
    end
    else
    begin
      case (pat)
        PAT_OFF:   txo_d = tx_data_in;
        PAT_PRBS:
        begin
          gen_d = gen_nxt;
          txo_d = gen_bits;
          txo_d[0] = gen_bits[0] ^ tx_force_err;
        end
        PAT_COMPL:
        begin
          ph_d  = !ph_q;
          txo_d = compl_w;
        end
        PAT_SQ2:   txo_d = sq2_w;
        PAT_SQW:   txo_d = sqw_w;
        default:   txo_d = '0;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      gen_q       <= `PRBS_SEED;
      ph_q        <= 1'b0;
      txs_q       <= `SEL_OFF;
      tx_data_out <= '0;
    end
    else
    begin
      gen_q       <= gen_d;
      ph_q        <= ph_d;
      txs_q       <= tx_sel;
      tx_data_out <= txo_d;
    end
  end

  // Receive checker state
  chk_e             chk_q, chk_d;
  logic [30:0]      hist_q, hist_nxt;
  logic [W-1:0]     exp_bits;
  logic [2:0]       rxs_q;
  logic [1:0]       hold_q, hold_d;
  logic             err_d, mism, chk_ok;
  logic [CNT_W-1:0] cnt_d;
  logic [DMON_W-1:0] dmon_d;

  // Expectation comes from received bits, so one bad bit repeats
  prbs_step #(.W(W)) u_chk (
    .state_i   (hist_q),
    .sel_i     (rx_sel),
    .use_ref_i (1'b1),
    .ref_i     (rx_data_in),
    .bits_o    (exp_bits),
    .state_o   (hist_nxt)
  );

  // Only the four PRBS codes are compared
  assign chk_ok = (rx_sel >= `SEL_PRBS7) && (rx_sel <= `SEL_PRBS31);
  assign mism   = |(exp_bits ^ rx_data_in);

  // Next checker state, flag and counter
  always_comb
  begin
    chk_d  = chk_q;
    hold_d = hold_q;
    err_d  = 1'b0;
    cnt_d  = rx_err_cnt;
    if (!chk_ok || rx_sel != rxs_q)
    begin
      // History refills before any report
      chk_d  = chk_ok ? CHK_SYNC : CHK_IDLE;
      hold_d = `CHK_HOLDOFF;
    end
    else
    begin
      case (chk_q)
        CHK_IDLE, CHK_SYNC:
        begin
          hold_d = hold_q - 2'h1;
          if (hold_q == 2'h1)
            chk_d = CHK_RUN;
        end
        CHK_RUN:   err_d = mism;
        default:   chk_d = CHK_IDLE;
      endcase
    end
    // Clear takes effect first; an error in the same cycle then counts as one
    if (rx_cnt_clr)
      cnt_d = '0;
    if (err_d && cnt_d != '1)
      cnt_d = cnt_d + 1'b1;
    dmon_d = DMON_W'({chk_q == CHK_RUN, rx_err_cnt});
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      chk_q      <= CHK_IDLE;
      hold_q     <= `CHK_HOLDOFF;
      hist_q     <= '0;
      rxs_q      <= `SEL_OFF;
      rx_err     <= 1'b0;
      rx_err_cnt <= '0;
      dmon_out   <= '0;
    end
    else
    begin
      chk_q      <= chk_d;
      hold_q     <= hold_d;
      hist_q     <= hist_nxt;
      rxs_q      <= rx_sel;
      rx_err     <= err_d;
      rx_err_cnt <= cnt_d;
      dmon_out   <= dmon_d;
    end
  end

  // Checks on the outputs against their causes
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  tx_off_pass_a: assert property (locked && tx_sel == `SEL_OFF && txs_q == `SEL_OFF
    |=> tx_data_out == $past(tx_data_in)) else $error("off mode data not passed");
  tx_sq2_a: assert property (locked && tx_sel == `SEL_SQ2 && txs_q == `SEL_SQ2
    |=> tx_data_out == sq2_w) else $error("2 UI square wrong");
  tx_sqw_a: assert property (locked && tx_sel == `SEL_SQW && txs_q == `SEL_SQW
    |=> tx_data_out[0] && !tx_data_out[W-1]) else $error("wide square wrong");
  tx_compl_a: assert property ((locked && tx_sel == `SEL_COMPL && txs_q == `SEL_COMPL)[*2]
    |=> (W != `COMPL_HALF) || tx_data_out != $past(tx_data_out))
    else $error("compliance halves not alternating");
  tx_force_a: assert property (locked && pat == PAT_PRBS && txs_q == tx_sel && tx_force_err
    |=> tx_data_out[0] != $past(gen_bits[0])) else $error("forced error missing");
  tx_lock_hold_a: assert property (!locked ##1 !locked
    |-> tx_data_out == '0) else $error("output active before lock");
  // Upper bits of a PRBS word are never touched by the forced error
  tx_prbs_word_a: assert property (locked && pat == PAT_PRBS && txs_q == tx_sel
    |=> tx_data_out[W-1:1] == $past(gen_bits[W-1:1])) else $error("PRBS word wrong");
  // Monitor bus mirrors the low bits of the count; the run-state bit is cut off at these widths
  dmon_mirror_a: assert property (1'b1
    |=> dmon_out == DMON_W'({$past(chk_q) == CHK_RUN, $past(rx_err_cnt)}))
    else $error("monitor bus wrong");
  // Checking off leaves the counter alone
  rx_off_cnt_a: assert property (rx_sel == `SEL_OFF && !rx_cnt_clr
    |=> $stable(rx_err_cnt)) else $error("counter moved while off");
  rx_err_now_a: assert property (chk_q == CHK_RUN && chk_ok && rx_sel == rxs_q
    |=> rx_err == $past(mism)) else $error("error flag not current");
  rx_nocheck_a: assert property (!chk_ok |=> !rx_err)
    else $error("checked a non-PRBS pattern");
  rx_resync_a: assert property (chk_ok && rx_sel != rxs_q
    |=> !rx_err [*3]) else $error("error during resync");
  cnt_clr_a: assert property (rx_cnt_clr |=> rx_err_cnt == CNT_W'(rx_err))
    else $error("counter not cleared");
  cnt_sat_a: assert property (rx_err_cnt == '1 && !rx_cnt_clr
    |=> rx_err_cnt == '1) else $error("counter wrapped");
  cnt_inc_a: assert property (!rx_cnt_clr && rx_err_cnt != '1 ##1 rx_err
    |-> rx_err_cnt == $past(rx_err_cnt) + 1'b1) else $error("counter missed error");

endmodule : lane_prbs_pattern_test

//--- hw/lane_test_consts.svh
/*
  Constants for the lane self-test block: select codes, LFSR taps,
  seed, checker hold-off and the compliance pattern.
  Assumes it is included by bare name from the design files.
*/
`ifndef LANE_TEST_CONSTS_SVH
`define LANE_TEST_CONSTS_SVH

// Select codes shared by generator and checker
`define SEL_OFF     3'h0
`define SEL_PRBS7   3'h1
`define SEL_PRBS15  3'h2
`define SEL_PRBS23  3'h3
`define SEL_PRBS31  3'h4
`define SEL_COMPL   3'h5
`define SEL_SQ2     3'h6
`define SEL_SQW     3'h7

// Feedback tap pairs (bit indices into the history register)
`define TAP7_A      6
`define TAP7_B      5
`define TAP15_A     14
`define TAP15_B     13
`define TAP23_A     22
`define TAP23_B     17
`define TAP31_A     30
`define TAP31_B     27

// Generator seed; all ones avoids the all-zero lock-up state
`define PRBS_SEED   31'h7FFFFFFF

// Words to hold off error reports after a checker select change
`define CHK_HOLDOFF 2'h3

// Compliance pattern, first bit on the line at bit 0
`define COMPL_PAT   40'hAAA835557C
`define COMPL_HALF  20
`define COMPL_FULL  40

`endif

//--- hw/lane_test_pkg.sv
/*
  Types for the lane self-test block.
  Assumes lane_test_consts.svh is visible to the design files.
*/
package lane_test_pkg;

  // Generator output source
  typedef enum logic [2:0] {
    PAT_OFF,
    PAT_PRBS,
    PAT_COMPL,
    PAT_SQ2,
    PAT_SQW
  } pat_e;

  // Checker state
  typedef enum logic [1:0] {
    CHK_IDLE,
    CHK_SYNC,
    CHK_RUN
  } chk_e;

endpackage : lane_test_pkg

//--- hw/prbs_step.sv
/*
  One word step of a pseudo-random shift register, shared by generator
  and checker. Assumes bit 0 of a word is the first bit on the line and
  that sel_i carries one of the select codes.
*/
`timescale 1ns/1ns
`include "lane_test_consts.svh"

module prbs_step #(
  parameter int W = 20
) (
  // History and mode
  input  wire logic [30:0]  state_i,
  input  wire logic [2:0]   sel_i,
  // Feed received bits instead of feedback
  input  wire logic         use_ref_i,
  input  wire logic [W-1:0] ref_i,
  // Result
  output logic      [W-1:0] bits_o,
  output logic      [30:0]  state_o
);

  // Serial recurrence unrolled over the word
  always_comb
  begin
    logic [30:0] s;
    logic        fb;
    s      = state_i;
    fb     = 1'b0;
    bits_o = '0;
    for (int i = 0; i < W; i++)
    begin
      case (sel_i)
        `SEL_PRBS7:  fb = s[`TAP7_A] ^ s[`TAP7_B];
        `SEL_PRBS15: fb = s[`TAP15_A] ^ s[`TAP15_B];
        `SEL_PRBS23: fb = s[`TAP23_A] ^ s[`TAP23_B];
        `SEL_PRBS31: fb = s[`TAP31_A] ^ s[`TAP31_B];
        default:     fb = 1'b0;
      endcase
      bits_o[i] = fb;
      s = {s[29:0], use_ref_i ? ref_i[i] : fb};
    end
    state_o = s;
  end

endmodule : prbs_step
